// File: src/rcd_decoder.v
// Serial command byte decoder for register access
// What this block does
// R1: Every transaction starts with a command byte
// R2: Command fixes next register and direction
// R3: Command accepted only when bit 7 low
// R4: Bit 6: zero writes, one reads
// R5: Bits 5:0 address; global register codes decoded
// R6: Codes 100000-100111 select setup 0-7
// R7: Filter 0-7 at 101000-101111
// R8: Channels 0-15, offsets and gains decoded
`timescale 1ns/100ps
`default_nettype none
`include "rcd_consts.vh"

module rcd_decoder (
  // Clock and reset
  input  wire       clock,
  input  wire       rst,
  // Serial pins from the host
  input  wire       sclk,
  input  wire       cs_n,
  input  wire       din,
  // Data phase handshake from the register logic
  input  wire       data_done,
  // Decoded command
  output reg  [7:0] command_entry,
  output reg        cmd_valid,
  output reg        cmd_read,
  output reg  [5:0] target_register_select,
  output reg  [3:0] target_class,
  output reg  [3:0] target_index,
  output reg        target_known,
  output reg        cmd_rejected,
  output reg        data_phase
);

  localparam [2:0] ST_CMD  = 3'b001;
  localparam [2:0] ST_DATA = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  wire sclk_s;
  wire cs_n_s;
  wire din_s;

  reg       sclk_prev_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [7:0] shift_q;
  reg [2:0] bit_cnt_q;
  reg [3:0] cls_d;
  reg [3:0] idx_d;
  reg [3:0] glob_cls;
  reg [3:0] bank_cls;
  reg [3:0] bank_idx;

  wire rise       = sclk_s & ~sclk_prev_q;
  wire [7:0] byte_in = {shift_q[6:0], din_s};
  wire [5:0] byte_addr = byte_in[`RCD_CMD_ADDR_MSB:`RCD_CMD_ADDR_LSB];
  wire byte_end   = rise & (bit_cnt_q == 3'h7) & ~cs_n_s;
  wire accept     = byte_end & (state_q == ST_CMD) & ~byte_in[`RCD_CMD_WEN_BIT]; // R3

  rcd_sync u_sync_sclk (
    .clock     (clock),
    .rst       (rst),
    .reset_val (1'b1),
    .pin       (sclk),
    .level     (sclk_s)
  );

  rcd_sync u_sync_cs (
    .clock     (clock),
    .rst       (rst),
    .reset_val (1'b1),
    .pin       (cs_n),
    .level     (cs_n_s)
  );

  rcd_sync u_sync_din (
    .clock     (clock),
    .rst       (rst),
    .reset_val (1'b0),
    .pin       (din),
    .level     (din_s)
  );

  // Global registers sit at fixed codes below the banks
  always @* begin
    glob_cls = `RCD_CLS_NONE;
    case (byte_addr)
      `RCD_RA_STATUS:    glob_cls = `RCD_CLS_STATUS;    // R5
      `RCD_RA_CONV_MODE: glob_cls = `RCD_CLS_CONV_MODE; // R5
      `RCD_RA_IF_MODE:   glob_cls = `RCD_CLS_IF_MODE;   // R5
      `RCD_RA_CHECKSUM:  glob_cls = `RCD_CLS_CHECKSUM;  // R5
      `RCD_RA_DATA:      glob_cls = `RCD_CLS_DATA;      // R5
      `RCD_RA_GPIO_CFG:  glob_cls = `RCD_CLS_GPIO_CFG;  // R5
      `RCD_RA_IDENT:     glob_cls = `RCD_CLS_IDENT;     // R5
      default:           glob_cls = `RCD_CLS_NONE;
    endcase
  end

  // Banks: channels by bits 5:4, the other banks by bits 5:3
  always @* begin
    bank_cls = `RCD_CLS_NONE;
    bank_idx = 4'h0;
    if (byte_addr[5:4] == `RCD_GRP_CHANNEL) begin
      bank_cls = `RCD_CLS_CHANNEL; // R8
      bank_idx = byte_addr[3:0];
    end else begin
      case (byte_addr[5:3])
        `RCD_GRP_SETUP:  bank_cls = `RCD_CLS_SETUP;  // R6
        `RCD_GRP_FILTER: bank_cls = `RCD_CLS_FILTER; // R7
        `RCD_GRP_OFFSET: bank_cls = `RCD_CLS_OFFSET; // R8
        `RCD_GRP_GAIN:   bank_cls = `RCD_CLS_GAIN;   // R8
        default:         bank_cls = `RCD_CLS_NONE;
      endcase
      if (bank_cls != `RCD_CLS_NONE) begin
        bank_idx = {1'b0, byte_addr[2:0]};
      end
    end
  end

  // Global codes never overlap a bank, so either side may answer
  always @* begin
    if (glob_cls != `RCD_CLS_NONE) begin
      cls_d = glob_cls;
      idx_d = 4'h0;
    end else begin
      cls_d = bank_cls;
      idx_d = bank_idx;
    end
  end

  // Only a byte taken in the command state opens a transaction
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_CMD: begin
        if (accept) begin
          state_d = ST_DATA; // R1
        end else if (byte_end) begin
          state_d = ST_WAIT;
        end
      end
      ST_DATA: begin
        if (data_done) begin
          state_d = ST_CMD; // R1
        end
      end
      ST_WAIT: begin
        state_d = ST_CMD;
      end
      default: state_d = ST_CMD;
    endcase
    // Deselect aborts any half done command or data phase
    if (cs_n_s) begin
      state_d = ST_CMD;
    end
  end

  // Edge detector and command state
  always @(posedge clock) begin
    if (rst) begin
      sclk_prev_q <= 1'b1;
      state_q     <= ST_CMD;
    end else begin
      sclk_prev_q <= sclk_s;
      state_q     <= state_d;
    end
  end

  // Bit counter only runs while hunting; a cut byte is dropped on deselect
  always @(posedge clock) begin
    if (rst) begin
      shift_q   <= 8'h00;
      bit_cnt_q <= 3'h0;
    end else if (cs_n_s || state_q != ST_CMD) begin
      bit_cnt_q <= 3'h0;
    end else if (rise) begin
      shift_q   <= byte_in;
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // One cycle strobes and the data phase level
  always @(posedge clock) begin
    if (rst) begin
      cmd_valid    <= 1'b0;
      cmd_rejected <= 1'b0;
      data_phase   <= 1'b0;
    end else begin
      cmd_valid    <= accept;
      cmd_rejected <= byte_end & (state_q == ST_CMD) & ~accept; // R3
      data_phase   <= (state_d == ST_DATA);                     // R2
    end
  end

  // Fields hold until the next accept, so a refused byte leaves them alone
  always @(posedge clock) begin
    if (rst) begin
      command_entry          <= `RCD_CMD_RESET;
      cmd_read               <= 1'b0;
      target_register_select <= 6'h00;
      target_class           <= `RCD_CLS_NONE;
      target_index           <= 4'h0;
      target_known           <= 1'b0;
    end else if (accept) begin
      command_entry          <= byte_in;                   // R2
      cmd_read               <= byte_in[`RCD_CMD_DIR_BIT]; // R4
      target_register_select <= byte_addr;                 // R5
      target_class           <= cls_d;                     // R2
      target_index           <= idx_d;
      target_known           <= (cls_d != `RCD_CLS_NONE);
    end
  end

endmodule // rcd_decoder

`default_nettype wire

// File: src/rcd_consts.vh
// Constants for the register access command decoder
`ifndef RCD_CONSTS_VH
`define RCD_CONSTS_VH

// Command entry register
`define RCD_CMD_OFFSET      8'h00
`define RCD_CMD_RESET       8'h00
`define RCD_CMD_WEN_BIT     7
`define RCD_CMD_DIR_BIT     6
`define RCD_CMD_ADDR_MSB    5
`define RCD_CMD_ADDR_LSB    0

// Global register address codes
`define RCD_RA_STATUS       6'h00
`define RCD_RA_CONV_MODE    6'h01
`define RCD_RA_IF_MODE      6'h02
`define RCD_RA_CHECKSUM     6'h03
`define RCD_RA_DATA         6'h04
`define RCD_RA_GPIO_CFG     6'h06
`define RCD_RA_IDENT        6'h07

// Banked register groups, selected by address bits 5:3 (or 5:4 for channels)
`define RCD_GRP_CHANNEL     2'h1
`define RCD_GRP_SETUP       3'h4
`define RCD_GRP_FILTER      3'h5
`define RCD_GRP_OFFSET      3'h6
`define RCD_GRP_GAIN        3'h7

// Register class codes on target_class
`define RCD_CLS_NONE        4'h0
`define RCD_CLS_STATUS      4'h1
`define RCD_CLS_CONV_MODE   4'h2
`define RCD_CLS_IF_MODE     4'h3
`define RCD_CLS_CHECKSUM    4'h4
`define RCD_CLS_DATA        4'h5
`define RCD_CLS_GPIO_CFG    4'h6
`define RCD_CLS_IDENT       4'h7
`define RCD_CLS_CHANNEL     4'h8
`define RCD_CLS_SETUP       4'h9
`define RCD_CLS_FILTER      4'ha
`define RCD_CLS_OFFSET      4'hb
`define RCD_CLS_GAIN        4'hc

`endif

// File: src/rcd_sync.v
// Two flip-flop synchroniser for one pin
`timescale 1ns/100ps
`default_nettype none

module rcd_sync (
  // Clock and reset
  input  wire clock,
  input  wire rst,
  input  wire reset_val,
  // Pin in, synchronised level out
  input  wire pin,
  output wire level
);

  reg meta_q;
  reg sync_q;

  always @(posedge clock) begin
    if (rst) begin
      meta_q <= reset_val;
      sync_q <= reset_val;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  assign level = sync_q;

endmodule // rcd_sync

`default_nettype wire

// File: dv/rcd_decoder_properties.sv
// Checks on the command decoder ports
`timescale 1ns/100ps
`default_nettype none
module rcd_props (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // Decoded command
  input wire logic       cmd_valid,
  input wire logic       cmd_read,
  input wire logic       cmd_rejected,
  input wire logic       data_phase,
  input wire logic [7:0] command_entry,
  input wire logic [5:0] target_register_select,
  input wire logic [3:0] target_class,
  input wire logic [3:0] target_index
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire [5:0] a = command_entry[5:0];
  a_accept_low: assert property (cmd_valid |-> !command_entry[7])
    else $error("accepted byte with bit 7 set");
  a_dir_bit: assert property (cmd_valid |-> cmd_read == command_entry[6])
    else $error("direction wrong");
  a_addr_field: assert property (cmd_valid |-> target_register_select == a)
    else $error("address field wrong");
  a_chan_map: assert property (cmd_valid && a[5:4] == 2'h1
    |-> target_class == 4'h8 && target_index == a[3:0]) else $error("channel map");
  a_setup_map: assert property (cmd_valid && a[5:3] == 3'h4
    |-> target_class == 4'h9 && target_index == a[2:0]) else $error("setup map");
  a_filter_map: assert property (cmd_valid && a[5:3] == 3'h5
    |-> target_class == 4'ha && target_index == a[2:0]) else $error("filter map");
  a_open_phase: assert property (cmd_valid |-> data_phase ##1 !cmd_valid)
    else $error("data phase not opened");
  a_hold_fields: assert property (!cmd_valid |-> $stable(command_entry))
    else $error("command changed without accept");
  a_reject_keep: assert property (cmd_rejected |-> !data_phase && !cmd_valid)
    else $error("rejected byte opened a phase");
  a_phase_from_cmd: assert property ($rose(data_phase) |-> cmd_valid)
    else $error("data phase opened without a command");
  // Main scenarios reached
  c_read: cover property (cmd_valid && cmd_read);
  c_write: cover property (cmd_valid && !cmd_read);
  c_reject: cover property (cmd_rejected);
endmodule // rcd_props
`default_nettype wire

// File: dv/rcd_host.sv
// Host side serial driver
`timescale 1ns/100ps
`default_nettype none
module rcd_host (
  // Clock
  input  wire       clock,
  // Serial pins toward the decoder
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic din
);
  initial begin
    sclk = 1;
    cs_n = 1;
    din = 0;
  end
  // Top n bits, MSB first, clock idles high between frames
  task automatic send(input logic [7:0] b, input int n = 8);
    cs_n <= 0;
    for (int i = 7; i > 7 - n; i--) begin
      repeat (4) @(posedge clock);
      sclk <= 0;
      din <= b[i];
      repeat (4) @(posedge clock);
      sclk <= 1;
    end
  endtask
  // Released line shows the inverse, not a stale value
  task automatic stop;
    repeat (4) @(posedge clock);
    cs_n <= 1;
    din <= ~din;
  endtask
endmodule // rcd_host
`default_nettype wire

// File: dv/rcd_decoder_tb_top.sv
// Bench for the command decoder
`timescale 1ns/100ps
`default_nettype none
module rcd_decoder_tb_top;
  logic clock = 0, rst = 1, data_done = 0, sclk, cs_n, din;
  logic cmd_valid, cmd_read, target_known, cmd_rejected, data_phase;
  logic [7:0] command_entry;
  logic [5:0] target_register_select;
  logic [3:0] target_class, target_index;
  int fail_count = 0, n_compared = 0;
  // Command byte, class, index
  logic [15:0] rows [18] = '{16'h0010, 16'h4120, 16'h0230, 16'h4340, 16'h4450,
    16'h0660, 16'h4770, 16'h5080, 16'h1f8f, 16'h6090, 16'h2797, 16'h28a0,
    16'h2fa7, 16'h70b0, 16'h37b7, 16'h78c0, 16'h3fc7, 16'h0500};
  rcd_host host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .din(din));
  rcd_decoder dut (.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .data_done(data_done), .command_entry(command_entry), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .target_register_select(target_register_select),
    .target_class(target_class), .target_index(target_index),
    .target_known(target_known), .cmd_rejected(cmd_rejected), .data_phase(data_phase));
  initial begin
    forever #10 clock = ~clock;
  end
  task automatic chk(input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask
  // Bounded wait for an accept or a refusal pulse
  task automatic wt(input bit rej);
    for (int k = 0; k < 12; k++) begin
      @(posedge clock);
      #1;
      if ((rej ? cmd_rejected : cmd_valid) === 1'b1) return;
    end
    chk(8'h00, 8'h01);
  endtask
  task automatic final_report;
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #300us;
    fail_count++;
    final_report;
  end
  initial begin
    repeat (4) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    #1 chk(command_entry, 8'h00);
    // Back to back commands, chip select held low throughout
    foreach (rows[i]) begin
      host.send(rows[i][15:8]);
      wt(0);
      chk(command_entry, rows[i][15:8]);
      chk(cmd_read, rows[i][14]);
      chk(target_register_select, rows[i][13:8]);
      chk({target_class, target_index}, rows[i][7:0]);
      chk(target_known, rows[i][7:4] != 0);
      chk(data_phase, 1);
      @(posedge clock) data_done <= 1;
      @(posedge clock) data_done <= 0;
      @(posedge clock);
      #1 chk(data_phase, 0);
    end
    host.send(8'hc4);
    wt(1);
    chk(command_entry, 8'h05);
    chk(data_phase, 0);
    host.send(8'h41);
    wt(0);
    chk(target_class, 4'h2);
    chk(data_phase, 1);
    // Bits clocked in during a data phase are not a new command
    host.send(8'h07);
    repeat (4) @(posedge clock);
    #1 chk(command_entry, 8'h41);
    // Deselect aborts the open phase
    host.stop;
    repeat (8) @(posedge clock);
    #1 chk(data_phase, 0);
    // A cut byte is dropped on deselect; the next whole byte is taken
    host.send(8'hf0, 4);
    host.stop;
    repeat (8) @(posedge clock);
    host.send(8'h02);
    wt(0);
    chk(command_entry, 8'h02);
    @(posedge clock) rst <= 1;
    repeat (4) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    #1 chk(command_entry, 8'h00);
    final_report;
  end
endmodule // rcd_decoder_tb_top
bind rcd_decoder rcd_props chk_i (.clock(clock), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_read(cmd_read), .cmd_rejected(cmd_rejected), .data_phase(data_phase),
  .command_entry(command_entry), .target_register_select(target_register_select),
  .target_class(target_class), .target_index(target_index));
`default_nettype wire
